// ---- design/intc_consts.svh ----
// Functional notes
// - enabled wakeup pin edge sets its flag
// - wakeup group enable gates all eight wakeups
// - mask bit set blocks every source
// - all wakeups share vector nine
// - each external pin picks rising or falling
// - enabled external pin edge sets its flag
// - each external pin has own enable
// - pin0 vector four, pin1 five, pin0 first
// - async pin senses rising, falling or both
// - async flag set only while enabled
// - async event uses vector six
// - seven internal sources, own flags, enables
// - internal vectors 20,19,18,15,14,12,11
// - accepting any interrupt sets mask bit
// - highest pending wins, others stay pending
// - accept only while mask bit clear
// - finish instruction, then stack pc and ccr
// - fetch vector, start handler there
// - set colliding with clear still wins
// - stack 4, vector 2, fetch 4, internal 4
// - flags clear by writing zero only
// - wakeup edge bit: 0 falling, 1 rising
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH
// register byte offsets
`define OFS_ENABLE_ONE   8'h00
`define OFS_ENABLE_TWO   8'h04
`define OFS_REQUEST_ONE  8'h08
`define OFS_REQUEST_TWO  8'h0c
`define OFS_WAKE_FLAGS   8'h10
`define OFS_WAKE_EDGE    8'h14
`define OFS_EXT_EDGE     8'h18
`define OFS_ASYNC_EDGE   8'h1c
`define OFS_PIN_MODE     8'h20
`define OFS_COND_CODE    8'h24
`define OFS_STATUS       8'h28
// field positions
`define BIT_EXT0         0
`define BIT_EXT1         1
`define BIT_ASYNC        2
`define BIT_WAKE_EN      7
`define BIT_MASK         7
`define BIT_PM_EXT0      8
`define BIT_PM_EXT1      9
// reset values
`define RST_BYTE         8'h00
`define RST_MASK         1'b1
`define RST_PIN_LEVEL    1'b1
// vector numbers
`define VEC_EXT0         5'd4
`define VEC_EXT1         5'd5
`define VEC_ASYNC        5'd6
`define VEC_WAKE         5'd9
`define VEC_INT0         5'd11
`define VEC_INT1         5'd12
`define VEC_INT2         5'd14
`define VEC_INT3         5'd15
`define VEC_INT4         5'd18
`define VEC_INT5         5'd19
`define VEC_INT6         5'd20
// exception sequence state counts
`define CNT_STACK        2'd3
`define CNT_VFETCH       2'd1
`define CNT_IFETCH       2'd3
`define CNT_INTERNAL     2'd3
`endif

// ---- design/intc_pkg.sv ----
package intc_pkg;
    // exception sequencer, gray coded along the path
    typedef enum logic [2:0] {
        st_idle     = 3'b000,
        st_finish   = 3'b001,
        st_stack    = 3'b011,
        st_vfetch   = 3'b010,
        st_ifetch   = 3'b110,
        st_internal = 3'b111
    } seq_state_type;
    // edge sensing modes
    typedef enum logic [1:0] {
        edge_fall = 2'b00,
        edge_rise = 2'b01,
        edge_both = 2'b10
    } edge_mode_type;
endpackage : intc_pkg

// ---- design/pin_edge_detect.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "intc_consts.svh"
module pin_edge_detect
    import intc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin,      // pin levels
    input  wire logic [WIDTH-1:0] func_en,  // pin assigned to interrupt function
    input  wire logic [2*WIDTH-1:0] mode,   // two mode bits per pin
    output logic      [WIDTH-1:0] hit       // one-cycle edge pulse
);
    logic [WIDTH-1:0] prev;                 // level seen last cycle

    // remember the last level, pins idle high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= {WIDTH{`RST_PIN_LEVEL}};
        end else begin
            prev <= pin;
        end
    end

    // per pin edge match against its mode
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            logic rise;
            logic fall;
            assign rise = pin[g] & ~prev[g];
            assign fall = ~pin[g] & prev[g];
            always_comb begin
                unique case (edge_mode_type'(mode[2*g +: 2]))
                    edge_fall: hit[g] = func_en[g] & fall;
                    edge_rise: hit[g] = func_en[g] & rise;
                    default:   hit[g] = func_en[g] & (rise | fall);
                endcase
            end
        end
    endgenerate
endmodule : pin_edge_detect
`default_nettype wire

// ---- design/priority_pick.sv ----
`timescale 1ns/1ns
`default_nettype none
module priority_pick #(
    parameter int WIDTH = 11,
    parameter int IDX_W = 4
) (
    input  wire logic [WIDTH-1:0] pending,  // bit 0 is highest priority
    output logic                  any,      // something pending
    output logic      [IDX_W-1:0] index     // winning position
);
    logic [WIDTH-1:0] lower_hit;            // a higher slot is already pending

    // each slot wins only when no higher slot is pending
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_slot
            if (g == 0) begin : g_first
                assign lower_hit[g] = 1'b0;
            end else begin : g_rest
                assign lower_hit[g] = lower_hit[g-1] | pending[g-1];
            end
        end
    endgenerate

    assign any = |pending;

    // encode the single winner
    always_comb begin
        index = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (pending[i] && !lower_hit[i]) begin
                index = IDX_W'(i);
            end
        end
    end
endmodule : priority_pick
`default_nettype wire

// ---- design/mcu_interrupt_controller.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "intc_consts.svh"
module mcu_interrupt_controller
    import intc_pkg::*;
#(
    parameter int NUM_WAKE = 8,
    parameter int NUM_INT  = 7,
    parameter int ADDR_W   = 16
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // interrupt pins, active low idle high
    input  wire logic [NUM_WAKE-1:0] wakeup_pins,
    input  wire logic                ext_int_pin_zero,
    input  wire logic                ext_int_pin_one,
    input  wire logic                async_event_int_pin,
    // peripheral request pulses
    input  wire logic [NUM_INT-1:0]  periph_req,
    // cpu core side
    input  wire logic                instr_done,
    input  wire logic [ADDR_W-1:0]   next_pc,
    input  wire logic [7:0]          core_flags,
    input  wire logic [ADDR_W-1:0]   vector_data,
    output logic                     stack_write,
    output logic      [ADDR_W-1:0]   stack_data,
    output logic                     vector_read,
    output logic      [ADDR_W-1:0]   vector_addr,
    output logic                     instr_fetch,
    output logic                     handler_start,
    output logic      [ADDR_W-1:0]   handler_addr,
    output logic                     global_mask
);
    localparam int NSRC  = 11;              // priority slots
    localparam int IDX_W = 4;

    // registers
    logic [7:0]  int_enable_reg_one;        // ext, async, two internal, wakeup group
    logic [7:0]  int_enable_reg_two;        // five internal enables
    logic [7:0]  int_request_reg_one;       // ext, async, two internal flags
    logic [7:0]  int_request_reg_two;       // five internal flags
    logic [7:0]  wakeup_request_flags;      // one flag per wakeup pin
    logic [7:0]  wakeup_edge_sel;           // 0 falling, 1 rising
    logic [7:0]  ext_pin_edge_select_reg;   // bit0 pin0, bit1 pin1
    logic [7:0]  async_edge_select_reg;     // two-bit edge field
    logic [15:0] pin_mode;                  // pin function assignment
    logic [7:0]  condition_code_reg;        // bit 7 is the global mask

    // decoded enables and pin functions
    logic        wakeup_group_enable;
    logic        ext_pin0_enable;
    logic        ext_pin1_enable;
    logic        async_pin_int_enable;
    logic        ext_pin0_edge_sel;
    logic        ext_pin1_edge_sel;
    logic        async_edge_sel_hi;
    logic        async_edge_sel_lo;

    assign wakeup_group_enable  = int_enable_reg_one[`BIT_WAKE_EN];
    assign ext_pin0_enable      = int_enable_reg_one[`BIT_EXT0];
    assign ext_pin1_enable      = int_enable_reg_one[`BIT_EXT1];
    assign async_pin_int_enable = int_enable_reg_one[`BIT_ASYNC];
    assign ext_pin0_edge_sel    = ext_pin_edge_select_reg[`BIT_EXT0];
    assign ext_pin1_edge_sel    = ext_pin_edge_select_reg[`BIT_EXT1];
    assign async_edge_sel_hi    = async_edge_select_reg[1];
    assign async_edge_sel_lo    = async_edge_select_reg[0];
    assign global_mask          = condition_code_reg[`BIT_MASK];

    // apb decode, zero wait states
    logic apb_wr;
    logic apb_rd;
    logic mapped;
    assign pready = 1'b1;
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & penable & ~pwrite;
    always_comb begin
        unique case (paddr)
            `OFS_ENABLE_ONE, `OFS_ENABLE_TWO, `OFS_REQUEST_ONE, `OFS_REQUEST_TWO,
            `OFS_WAKE_FLAGS, `OFS_WAKE_EDGE, `OFS_EXT_EDGE, `OFS_ASYNC_EDGE,
            `OFS_PIN_MODE, `OFS_COND_CODE, `OFS_STATUS: mapped = 1'b1;
            default:                                    mapped = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~mapped;

    // write strobes per register
    logic wr_en1, wr_en2, wr_rq1, wr_rq2, wr_wf, wr_we, wr_ee, wr_ae, wr_pm, wr_cc;
    assign wr_en1 = apb_wr & (paddr == `OFS_ENABLE_ONE);
    assign wr_en2 = apb_wr & (paddr == `OFS_ENABLE_TWO);
    assign wr_rq1 = apb_wr & (paddr == `OFS_REQUEST_ONE);
    assign wr_rq2 = apb_wr & (paddr == `OFS_REQUEST_TWO);
    assign wr_wf  = apb_wr & (paddr == `OFS_WAKE_FLAGS);
    assign wr_we  = apb_wr & (paddr == `OFS_WAKE_EDGE);
    assign wr_ee  = apb_wr & (paddr == `OFS_EXT_EDGE);
    assign wr_ae  = apb_wr & (paddr == `OFS_ASYNC_EDGE);
    assign wr_pm  = apb_wr & (paddr == `OFS_PIN_MODE);
    assign wr_cc  = apb_wr & (paddr == `OFS_COND_CODE);

    // plain control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_enable_reg_one      <= `RST_BYTE;
            int_enable_reg_two      <= `RST_BYTE;
            wakeup_edge_sel         <= `RST_BYTE;
            ext_pin_edge_select_reg <= `RST_BYTE;
            async_edge_select_reg   <= `RST_BYTE;
            pin_mode                <= {`RST_BYTE, `RST_BYTE};
        end else begin
            if (wr_en1) int_enable_reg_one      <= pwdata[7:0];
            if (wr_en2) int_enable_reg_two      <= pwdata[7:0];
            if (wr_we)  wakeup_edge_sel         <= pwdata[7:0];
            if (wr_ee)  ext_pin_edge_select_reg <= pwdata[7:0];
            if (wr_ae)  async_edge_select_reg   <= pwdata[7:0];
            if (wr_pm)  pin_mode                <= pwdata[15:0];
        end
    end

    // edge detection, wakeup pins one bit per pin
    logic [NUM_WAKE-1:0]   wake_hit;
    logic [2*NUM_WAKE-1:0] wake_mode;
    always_comb begin
        for (int i = 0; i < NUM_WAKE; i++) begin
            wake_mode[2*i +: 2] = {1'b0, wakeup_edge_sel[i]};
        end
    end
    pin_edge_detect #(.WIDTH(NUM_WAKE)) u_wake_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (wakeup_pins),
        .func_en (pin_mode[NUM_WAKE-1:0]),
        .mode    (wake_mode),
        .hit     (wake_hit)
    );

    // external pins and async pin share one detector
    logic [2:0] misc_hit;
    pin_edge_detect #(.WIDTH(3)) u_misc_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({async_event_int_pin, ext_int_pin_one, ext_int_pin_zero}),
        .func_en ({async_pin_int_enable, pin_mode[`BIT_PM_EXT1], pin_mode[`BIT_PM_EXT0]}),
        .mode    ({async_edge_sel_hi, async_edge_sel_lo,
                   1'b0, ext_pin1_edge_sel, 1'b0, ext_pin0_edge_sel}),
        .hit     (misc_hit)
    );

    // set vectors into the request registers
    logic [7:0] set_rq1;
    logic [7:0] set_rq2;
    always_comb begin
        set_rq1            = '0;
        set_rq2            = '0;
        set_rq1[`BIT_EXT0] = misc_hit[0];
        set_rq1[`BIT_EXT1] = misc_hit[1];
        set_rq1[`BIT_ASYNC]= misc_hit[2];
        set_rq2[0]         = periph_req[0];
        set_rq2[2]         = periph_req[1];
        set_rq2[3]         = periph_req[2];
        set_rq1[4]         = periph_req[3];
        set_rq1[5]         = periph_req[4];
        set_rq2[6]         = periph_req[5];
        set_rq2[7]         = periph_req[6];
    end

    // flags: write 0 clears, write 1 keeps, hardware set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_request_reg_one  <= `RST_BYTE;
            int_request_reg_two  <= `RST_BYTE;
            wakeup_request_flags <= `RST_BYTE;
        end else begin
            int_request_reg_one  <= (int_request_reg_one & (wr_rq1 ? pwdata[7:0] : 8'hff))
                                    | set_rq1;
            int_request_reg_two  <= (int_request_reg_two & (wr_rq2 ? pwdata[7:0] : 8'hff))
                                    | set_rq2;
            wakeup_request_flags <= (wakeup_request_flags & (wr_wf ? pwdata[7:0] : 8'hff))
                                    | wake_hit;
        end
    end

    // enabled requests in priority order, lowest vector first
    logic [NSRC-1:0] req1_on;
    logic [7:0]      r1;
    logic [7:0]      r2;
    assign r1 = int_request_reg_one & int_enable_reg_one;
    assign r2 = int_request_reg_two & int_enable_reg_two;
    assign req1_on = {r2[7], r2[6], r1[5], r1[4], r2[3], r2[2], r2[0],
                      wakeup_group_enable & (|wakeup_request_flags),
                      r1[`BIT_ASYNC], r1[`BIT_EXT1], r1[`BIT_EXT0]};

    logic             any_pending;
    logic [IDX_W-1:0] win_index;
    priority_pick #(.WIDTH(NSRC), .IDX_W(IDX_W)) u_pick (
        .pending (req1_on),
        .any     (any_pending),
        .index   (win_index)
    );

    // slot to vector number
    logic [4:0] win_vector;
    always_comb begin
        unique case (win_index)
            4'd0:    win_vector = `VEC_EXT0;
            4'd1:    win_vector = `VEC_EXT1;
            4'd2:    win_vector = `VEC_ASYNC;
            4'd3:    win_vector = `VEC_WAKE;
            4'd4:    win_vector = `VEC_INT0;
            4'd5:    win_vector = `VEC_INT1;
            4'd6:    win_vector = `VEC_INT2;
            4'd7:    win_vector = `VEC_INT3;
            4'd8:    win_vector = `VEC_INT4;
            4'd9:    win_vector = `VEC_INT5;
            4'd10:   win_vector = `VEC_INT6;
            default: win_vector = `VEC_EXT0;
        endcase
    end

    // exception sequencer
    seq_state_type state;
    seq_state_type next_state;
    logic [1:0]    step;                    // cycles left in a phase
    logic          accept;
    logic          phase_end;
    logic [4:0]    taken_vector;            // vector latched at accept
    assign accept    = (state == st_idle) & any_pending & ~global_mask;
    assign phase_end = (step == 2'd0);

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle:     if (accept) next_state = st_finish;
            st_finish:   if (instr_done) next_state = st_stack;
            st_stack:    if (phase_end) next_state = st_vfetch;
            st_vfetch:   if (phase_end) next_state = st_ifetch;
            st_ifetch:   if (phase_end) next_state = st_internal;
            st_internal: if (phase_end) next_state = st_idle;
            default:     next_state = st_idle;
        endcase
    end

    // state and phase counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
            step  <= 2'd0;
        end else begin
            state <= next_state;
            if (state != next_state) begin
                unique case (next_state)
                    st_stack:    step <= `CNT_STACK;
                    st_vfetch:   step <= `CNT_VFETCH;
                    st_ifetch:   step <= `CNT_IFETCH;
                    st_internal: step <= `CNT_INTERNAL;
                    default:     step <= 2'd0;
                endcase
            end else if (!phase_end) begin
                step <= step - 2'd1;
            end
        end
    end

    // condition codes: software access, mask set at end of stacking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            condition_code_reg           <= {`RST_MASK, 7'h00};
        end else begin
            if (wr_cc) condition_code_reg <= pwdata[7:0];
            if (state == st_stack && next_state == st_vfetch) begin
                condition_code_reg[`BIT_MASK] <= 1'b1;
            end
        end
    end

    // stacked words, pc first then condition codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_data <= '0;
        end else if (state == st_finish && instr_done) begin
            stack_data <= next_pc;
        end else if (state == st_stack && step == 2'd2) begin
            stack_data <= {core_flags, condition_code_reg};
        end
    end

    // vector capture and handler address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_vector <= 5'd0;
            vector_addr  <= '0;
            handler_addr <= '0;
        end else begin
            if (accept) taken_vector <= win_vector;
            if (state == st_stack && phase_end) begin
                vector_addr <= ADDR_W'({taken_vector, 1'b0});
            end
            if (state == st_vfetch && phase_end) begin
                handler_addr <= vector_data;
            end
        end
    end

    // handler start pulse at end of internal phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handler_start <= 1'b0;
        end else begin
            handler_start <= (state == st_internal) & phase_end;
        end
    end

    assign stack_write = (state == st_stack);
    assign vector_read = (state == st_vfetch);
    assign instr_fetch = (state == st_ifetch);

    // read data
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        unique case (paddr)
            `OFS_ENABLE_ONE:  next_rdata[7:0]  = int_enable_reg_one;
            `OFS_ENABLE_TWO:  next_rdata[7:0]  = int_enable_reg_two;
            `OFS_REQUEST_ONE: next_rdata[7:0]  = int_request_reg_one;
            `OFS_REQUEST_TWO: next_rdata[7:0]  = int_request_reg_two;
            `OFS_WAKE_FLAGS:  next_rdata[7:0]  = wakeup_request_flags;
            `OFS_WAKE_EDGE:   next_rdata[7:0]  = wakeup_edge_sel;
            `OFS_EXT_EDGE:    next_rdata[7:0]  = ext_pin_edge_select_reg;
            `OFS_ASYNC_EDGE:  next_rdata[7:0]  = async_edge_select_reg;
            `OFS_PIN_MODE:    next_rdata[15:0] = pin_mode;
            `OFS_COND_CODE:   next_rdata[7:0]  = condition_code_reg;
            `OFS_STATUS:      next_rdata[12:0] = {any_pending, state, win_vector, taken_vector[3:0]};
            default:          next_rdata       = '0;
        endcase
    end
    assign prdata = apb_rd ? next_rdata : 32'h0;
endmodule : mcu_interrupt_controller
`default_nettype wire

// ---- verif/intc_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module intc_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic instr_done,
    input wire logic stack_write,
    input wire logic vector_read,
    input wire logic instr_fetch,
    input wire logic handler_start,
    input wire logic global_mask,
    input wire logic [15:0] stack_data,
    input wire logic [15:0] next_pc
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_stack_len: assert property ($rose(stack_write) |-> stack_write[*4] ##1 !stack_write)
        else $error("stack phase not four cycles");
    a_after_done: assert property ($rose(stack_write) |-> $past(instr_done))
        else $error("stacking began before instruction end");
    a_accept_unmasked: assert property ($rose(stack_write) |-> !global_mask)
        else $error("request accepted while masked");
    a_vector_len: assert property ($fell(stack_write) |-> vector_read[*2] ##1 !vector_read)
        else $error("vector fetch not two cycles after stacking");
    a_mask_set: assert property ($fell(stack_write) |-> global_mask)
        else $error("mask not set on entry");
    a_fetch_len: assert property ($fell(vector_read) |-> instr_fetch[*4] ##1 !instr_fetch)
        else $error("instruction fetch not four cycles");
    a_handler_time: assert property ($fell(instr_fetch) |-> !handler_start[*4] ##1 handler_start)
        else $error("handler start not after four internal cycles");
    a_phase_excl: assert property (stack_write |-> !vector_read && !instr_fetch)
        else $error("exception phases overlap");
    a_stack_pc: assert property ($rose(stack_write) |-> stack_data == $past(next_pc))
        else $error("stacked return address wrong");
    // main scenarios reached
    c_stack: cover property ($rose(stack_write));
    c_handler: cover property (handler_start);
    c_masked_done: cover property (global_mask && instr_done);
endmodule : intc_props
bind mcu_interrupt_controller intc_props u_props (.pclk(pclk), .presetn(presetn), .instr_done(instr_done),
    .stack_write(stack_write), .vector_read(vector_read), .instr_fetch(instr_fetch),
    .handler_start(handler_start), .global_mask(global_mask), .stack_data(stack_data), .next_pc(next_pc));
`default_nettype wire

// ---- verif/cpu_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        vector_read,
    input  wire logic [15:0] vector_addr,
    output logic             instr_done,
    output logic      [15:0] next_pc,
    output logic      [7:0]  core_flags,
    output logic      [15:0] vector_data
);
    logic [3:0] len; // states of running instruction
    logic [3:0] cnt; // states spent so far
    // retire instructions of 1 to 13 states in turn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            len <= 4'h1;
            instr_done <= 1'b0;
            next_pc <= 16'h0100;
        end else if (cnt == len - 4'h1) begin
            cnt <= 4'h0;
            len <= (len == 4'hd) ? 4'h1 : len + 4'h1;
            instr_done <= 1'b1;
            next_pc <= next_pc + 16'h0002;
        end else begin
            cnt <= cnt + 4'h1;
            instr_done <= 1'b0;
        end
    end
    assign core_flags = next_pc[8:1];
    // table answers only while read, else a moving pattern
    assign vector_data = vector_read ? {vector_addr[7:0], 8'h5a} : ~(next_pc + {12'h0, cnt});
endmodule : cpu_core_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, ext0, ext1, apin, er;
    logic instr_done, stack_write, vector_read, instr_fetch, handler_start, global_mask;
    logic [7:0] paddr, wake, core_flags;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] next_pc, vector_data, vector_addr, handler_addr;
    logic [6:0] preq;
    logic [2:0] j;
    logic [15:0] exp_q[$]; // expected handler addresses
    logic [4:0] ivec[7] = '{5'd11, 5'd12, 5'd14, 5'd15, 5'd18, 5'd19, 5'd20};
    int n_fail, check_count, cycles;
    mcu_interrupt_controller DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wakeup_pins(wake), .ext_int_pin_zero(ext0), .ext_int_pin_one(ext1),
        .async_event_int_pin(apin), .periph_req(preq), .instr_done(instr_done), .next_pc(next_pc),
        .core_flags(core_flags), .vector_data(vector_data), .stack_write(stack_write), .stack_data(),
        .vector_read(vector_read), .vector_addr(vector_addr), .instr_fetch(instr_fetch),
        .handler_start(handler_start), .handler_addr(handler_addr), .global_mask(global_mask));
    cpu_core_model core (.pclk(pclk), .presetn(presetn), .vector_read(vector_read),
        .vector_addr(vector_addr), .instr_done(instr_done), .next_pc(next_pc),
        .core_flags(core_flags), .vector_data(vector_data));
    always #5 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task fail(input string m);
        n_fail++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail
    task give_verdict;
        $display("mismatches %0d checks %0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check_count++;
        if (rd !== e) fail($sformatf("read %h got %h", a, rd));
    endtask : chk
    // note handler, unmask, wait for it
    task serve(input logic [4:0] v);
        exp_q.push_back({2'b00, v, 1'b0, 8'h5a});
        wr(8'h24, 32'h0);
        for (int k = 0; k < 80 && exp_q.size() != 0; k++) @(posedge pclk);
        if (exp_q.size() != 0) fail("handler missing");
    endtask : serve
    // watch handler entries against notes
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
        if (handler_start === 1'b1) begin
            check_count++;
            if (exp_q.size() == 0) fail("unexpected handler");
            else if (handler_addr !== exp_q.pop_front()) fail("wrong handler");
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, preq} = '0;
        {wake, ext0, ext1, apin} = 11'h7ff;
        {n_fail, check_count, cycles} = '0;
        seed = xs(32'd74);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(8'h24, 32'h80);
        chk(8'h14, 32'h0);
        apb(1'b0, 8'h2c, 32'h0);
        check_count++;
        if (er !== 1'b1) fail("unmapped read accepted");
        wr(8'h14, {24'h0, seed[7:0]});
        chk(8'h14, {24'h0, seed[7:0]});
        wr(8'h14, 32'h0);
        wr(8'h20, 32'h3ff);
        wr(8'h00, 32'hb7);
        wr(8'h04, 32'hcd);
        wr(8'h1c, 32'h2);
        {ext0, ext1} <= 2'b00;
        repeat (30) @(posedge pclk);
        chk(8'h08, 32'h3);
        serve(5'd4);
        chk(8'h08, 32'h3);
        wr(8'h08, 32'h2);
        chk(8'h08, 32'h2);
        serve(5'd5);
        wr(8'h08, 32'h0);
        {ext0, ext1} <= 2'b11;
        for (int i = 0; i < 7; i++) begin
            @(posedge pclk) preq <= 7'd1 << i;
            @(posedge pclk) preq <= 7'd0;
            serve(ivec[i]);
            wr(8'h08, 32'h0);
            wr(8'h0c, 32'h0);
        end
        j = seed[10:8];
        wake[j] <= 1'b0;
        repeat (3) @(posedge pclk);
        serve(5'd9);
        chk(8'h10, 32'h1 << j);
        wake[j] <= 1'b1;
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h37);
        wake[j] <= 1'b0;
        repeat (3) @(posedge pclk);
        wr(8'h24, 32'h0);
        repeat (40) @(posedge pclk);
        chk(8'h10, 32'h1 << j);
        wr(8'h24, 32'h80);
        wake[j] <= 1'b1;
        wr(8'h10, 32'h0);
        wr(8'h00, 32'hb7);
        apin <= 1'b0;
        repeat (3) @(posedge pclk);
        serve(5'd6);
        wr(8'h08, 32'h0);
        apin <= 1'b1;
        repeat (3) @(posedge pclk);
        serve(5'd6);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'hb3);
        apin <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(8'h08, 32'h0);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
